// ---- shared/scg_defs.svh ----
`ifndef SCG_DEFS_SVH
`define SCG_DEFS_SVH
// ----------------------------------------
// Widths and defaults
// ----------------------------------------
`define SCG_GEAR_W        16
`define SCG_GEAR_NUM_RST  16'h0004
`define SCG_GEAR_DEN_RST  16'h0001
`define SCG_QUAD_FACTOR   4
`define SCG_SPD_W         16
`define SCG_SPD_LIMIT_MAX 16'h2710
`define SCG_OPT_W         17
`define SCG_OPT_FULL      17'h186a0
`define SCG_POS_W         32
`define SCG_SRC_OPTION    2'h1
`define SCG_FILT_NONE     2'h0
`define SCG_FILT_EXP      2'h1
`define SCG_FILT_AVG      2'h2
`define SCG_AVG_DEPTH     16
`define SCG_AVG_LOG2      4
`endif

// ---- shared/scg_pkg.sv ----
package scg_pkg;
    // Position command pulse from the host side
    typedef struct packed {
        logic        valid;
        logic [15:0] count;
    } scg_cmd_s;
    // Profile motion phase
    typedef enum {SCG_IDLE, SCG_ACCEL, SCG_CRUISE, SCG_DECEL} scg_phase_e;
endpackage : scg_pkg

// ---- verilog/scg_servo_cond.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "scg_defs.svh"
module scg_servo_cond #(
    parameter int GEAR_W = `SCG_GEAR_W,
    parameter int SPD_W  = `SCG_SPD_W,
    parameter int POS_W  = `SCG_POS_W
) (
    input  wire logic                clk,
    input  wire logic                nrst,
    input  wire scg_pkg::scg_cmd_s   cmdIn,
    input  wire logic [GEAR_W-1:0]   gearNumeratorParam,
    input  wire logic [GEAR_W-1:0]   gearDenominatorParam,
    input  wire logic                torqueMode,
    input  wire logic signed [SPD_W:0] motorSpeed,
    input  wire logic [SPD_W-1:0]    maxMotorSpeed,
    input  wire logic [SPD_W-1:0]    torqueModeSpeedLimit,
    input  wire logic [1:0]          speedCommandSourceSelect,
    input  wire logic [`SCG_OPT_W-1:0] optionCommand1,
    input  wire logic                speedLimitOutputAlloc,
    input  wire logic [SPD_W-1:0]    limitGain,
    input  wire logic [POS_W-1:0]    feedbackPos,
    input  wire logic [SPD_W-1:0]    accelStepOne,
    input  wire logic [SPD_W-1:0]    accelStepTwo,
    input  wire logic [SPD_W-1:0]    accelSwitchSpeed,
    input  wire logic [SPD_W-1:0]    decelStepOne,
    input  wire logic [SPD_W-1:0]    decelStepTwo,
    input  wire logic [SPD_W-1:0]    decelSwitchSpeed,
    input  wire logic [SPD_W-1:0]    targetSpeed,
    input  wire logic                profileRun,
    input  wire logic [1:0]          filterSelect,
    input  wire logic [SPD_W-1:0]    expFilterBias,
    input  wire logic [3:0]          expFilterTimeConstant,
    input  wire logic [`SCG_AVG_LOG2:0] movingAverageTime,
    output logic [POS_W-1:0]         motorPulseTotal,
    output logic [POS_W-1:0]         deviationCmdUnits,
    output logic signed [SPD_W+1:0]  limitTorque,
    output logic                     speedLimitDetected,
    output logic [SPD_W-1:0]         profileSpeed,
    output logic [SPD_W-1:0]         filteredSpeed
);
    import scg_pkg::*;

    // ----------------------------------------
    // Electronic gear
    // ----------------------------------------
    logic [GEAR_W-1:0] gearNum_r;           // Ratio latched at power-up only
    logic [GEAR_W-1:0] gearDen_r;
    logic              gearLoaded_r;        // Catches params once after reset
    logic [POS_W-1:0]  remainder_r;         // Carry of each division
    logic [POS_W-1:0]  cmdTotal_r;          // Command units received
    logic [POS_W+GEAR_W-1:0] product;
    logic [POS_W-1:0]  dividend;
    logic [POS_W-1:0]  quotient;
    logic [POS_W-1:0]  remNxt;

    // Params caught by clock after reset release; later edits wait for power cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gearNum_r    <= `SCG_GEAR_NUM_RST;
            gearDen_r    <= `SCG_GEAR_DEN_RST;
            gearLoaded_r <= 1'b0;
        end else if (!gearLoaded_r) begin
            gearNum_r    <= gearNumeratorParam;
            gearDen_r    <= (gearDenominatorParam == '0) ? `SCG_GEAR_DEN_RST
                                                         : gearDenominatorParam;
            gearLoaded_r <= 1'b1;
        end
    end

    // Divider is combinational; fine at 20 MHz for these widths
    always_comb begin
        product  = {{POS_W{1'b0}}, cmdIn.count} * {{POS_W{1'b0}}, gearNum_r};
        dividend = product[POS_W-1:0] + remainder_r;
        quotient = dividend / {{(POS_W-GEAR_W){1'b0}}, gearDen_r};
        remNxt   = dividend - quotient * {{(POS_W-GEAR_W){1'b0}}, gearDen_r};
    end

    // Output pulses are quad-resolution encoder counts
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            remainder_r     <= '0;
            motorPulseTotal <= '0;
            cmdTotal_r      <= '0;
        end else if (cmdIn.valid && gearLoaded_r) begin
            remainder_r     <= remNxt;
            motorPulseTotal <= motorPulseTotal + quotient;
            cmdTotal_r      <= cmdTotal_r + {{(POS_W-16){1'b0}}, cmdIn.count};
        end
    end

    // Deviation kept in command units, not encoder counts
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            deviationCmdUnits <= '0;
        end else begin
            deviationCmdUnits <= cmdTotal_r - (feedbackPos * gearDen_r) / gearNum_r;
        end
    end

    // ----------------------------------------
    // Speed limit in torque control
    // ----------------------------------------
    logic [SPD_W-1:0] fixedLimit;
    logic [SPD_W-1:0] optLimit;
    logic [SPD_W-1:0] activeLimit;
    logic [SPD_W:0]   absSpeed;
    logic [SPD_W:0]   excess;
    logic [SPD_W+SPD_W+`SCG_OPT_W-1:0] optProd;

    always_comb begin
        fixedLimit = (torqueModeSpeedLimit > `SCG_SPD_LIMIT_MAX) ? `SCG_SPD_LIMIT_MAX
                                                                 : torqueModeSpeedLimit;
        optProd  = {{(SPD_W+SPD_W){1'b0}}, (optionCommand1 > `SCG_OPT_FULL) ?
                    `SCG_OPT_FULL : optionCommand1} * maxMotorSpeed;
        optLimit = SPD_W'(optProd / `SCG_OPT_FULL);
        activeLimit = fixedLimit;
        if (speedCommandSourceSelect == `SCG_SRC_OPTION && optLimit < fixedLimit) begin
            activeLimit = optLimit;
        end
        // Magnitude compare gives both directions the same limit
        absSpeed = motorSpeed[SPD_W] ? (SPD_W+1)'(-motorSpeed) : motorSpeed;
        excess   = (absSpeed > {1'b0, activeLimit}) ? absSpeed - {1'b0, activeLimit} : '0;
    end

    // Opposing torque is the overspeed ANDed bitwise with limitGain; no multiply or shift
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            limitTorque        <= '0;
            speedLimitDetected <= 1'b0;
        end else begin
            if (torqueMode && excess != '0) begin
                limitTorque <= motorSpeed[SPD_W] ?
                    (SPD_W+2)'(excess[SPD_W-1:0] & limitGain)
                  : -(SPD_W+2)'(excess[SPD_W-1:0] & limitGain);
            end else begin
                limitTorque <= '0;
            end
            speedLimitDetected <= torqueMode && excess != '0 && speedLimitOutputAlloc;
        end
    end

    // ----------------------------------------
    // Two-step acceleration profile
    // ----------------------------------------
    scg_phase_e phase_r;
    logic [SPD_W-1:0] step;
    logic [SPD_W:0]   upSpeed;

    always_comb begin
        case (phase_r)
            SCG_ACCEL: step = (profileSpeed < accelSwitchSpeed) ? accelStepOne
                                                                : accelStepTwo;
            SCG_DECEL: step = (profileSpeed < decelSwitchSpeed) ? decelStepOne
                                                                : decelStepTwo;
            default:   step = '0;
        endcase
        upSpeed = {1'b0, profileSpeed} + {1'b0, step};
    end

    // Phase follows target; settings come from the host link
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phase_r      <= SCG_IDLE;
            profileSpeed <= '0;
        end else begin
            case (phase_r)
                SCG_IDLE: begin
                    if (profileRun && targetSpeed != profileSpeed) begin
                        phase_r <= (targetSpeed > profileSpeed) ? SCG_ACCEL : SCG_DECEL;
                    end
                end
                SCG_ACCEL: begin
                    if (upSpeed >= {1'b0, targetSpeed}) begin
                        profileSpeed <= targetSpeed;
                        phase_r      <= SCG_CRUISE;
                    end else begin
                        profileSpeed <= upSpeed[SPD_W-1:0];
                    end
                end
                SCG_DECEL: begin
                    if (profileSpeed <= targetSpeed + step || profileSpeed < step) begin
                        profileSpeed <= targetSpeed;
                        phase_r      <= SCG_CRUISE;
                    end else begin
                        profileSpeed <= profileSpeed - step;
                    end
                end
                SCG_CRUISE: begin
                    if (!profileRun) begin
                        phase_r <= (profileSpeed != '0) ? SCG_DECEL : SCG_IDLE;
                    end else if (targetSpeed != profileSpeed) begin
                        phase_r <= (targetSpeed > profileSpeed) ? SCG_ACCEL : SCG_DECEL;
                    end
                end
                default: phase_r <= SCG_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Position command filters
    // ----------------------------------------
    logic [SPD_W-1:0]   avgMem [`SCG_AVG_DEPTH];   // Sliding window
    logic [SPD_W+`SCG_AVG_LOG2:0] avgSum_r;
    logic [`SCG_AVG_LOG2-1:0]     avgPtr_r;
    logic [SPD_W+8:0]   expAcc_r;                  // Exponential state, fraction bits
    logic [SPD_W-1:0]   expIn;
    logic [SPD_W-1:0]   avgOut;
    // Signed step toward the input; an unsigned one wraps when speed falls
    logic signed [SPD_W+9:0] expDiff;

    // Window length is a power of two so average is a shift
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            avgSum_r <= '0;
            avgPtr_r <= '0;
            for (int i = 0; i < `SCG_AVG_DEPTH; i++) avgMem[i] <= '0;
        end else begin
            avgMem[avgPtr_r] <= profileSpeed;
            avgSum_r <= avgSum_r + profileSpeed - avgMem[avgPtr_r];
            avgPtr_r <= avgPtr_r + 1'b1;
        end
    end
    assign avgOut = SPD_W'(avgSum_r >> `SCG_AVG_LOG2);

    // Bias makes the output follow directly below that speed
    assign expIn = (profileSpeed > expFilterBias) ? profileSpeed - expFilterBias : '0;
    assign expDiff = $signed({1'b0, expIn, 9'h000}) - $signed({1'b0, expAcc_r});

    // Arithmetic shift floors toward minus one, so a falling input decays to zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            expAcc_r <= '0;
        end else begin
            expAcc_r <= expAcc_r + (SPD_W+9)'(expDiff >>> expFilterTimeConstant);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            filteredSpeed <= '0;
        end else begin
            case (filterSelect)
                `SCG_FILT_EXP: filteredSpeed <= SPD_W'(expAcc_r >> 9) +
                    ((profileSpeed > expFilterBias) ? expFilterBias : profileSpeed);
                `SCG_FILT_AVG: filteredSpeed <= (movingAverageTime != '0) ? avgOut
                                                                         : profileSpeed;
                default:       filteredSpeed <= profileSpeed;
            endcase
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    AST_GEAR_HOLD: assert property (@(posedge clk) disable iff (!nrst)
        gearLoaded_r |=> $stable(gearNum_r) && $stable(gearDen_r))
        else $error("gear ratio changed after load");
    AST_DEFAULT_GEAR: assert property (@(posedge clk) disable iff (!nrst)
        !gearLoaded_r |-> gearNum_r == `SCG_GEAR_NUM_RST)
        else $error("default gear not four");
    AST_PULSES: assert property (@(posedge clk) disable iff (!nrst)
        cmdIn.valid && gearLoaded_r |=> motorPulseTotal == $past(motorPulseTotal) + $past(quotient))
        else $error("pulse total wrong");
    AST_REM: assert property (@(posedge clk) disable iff (!nrst)
        remainder_r < {{(POS_W-GEAR_W){1'b0}}, gearDen_r} || !gearLoaded_r)
        else $error("remainder not below denominator");
    AST_FLAG: assert property (@(posedge clk) disable iff (!nrst)
        speedLimitDetected |-> $past(speedLimitOutputAlloc) && $past(torqueMode))
        else $error("flag without cause");
    AST_MIN: assert property (@(posedge clk) disable iff (!nrst)
        activeLimit <= fixedLimit &&
        (speedCommandSourceSelect != `SCG_SRC_OPTION || activeLimit <= optLimit))
        else $error("limit not smallest");
    // Fixed limit never above its top setting
    AST_FIXED_CLAMP: assert property (@(posedge clk) disable iff (!nrst)
        fixedLimit <= `SCG_SPD_LIMIT_MAX)
        else $error("fixed limit above range");
    // No flag while out of torque control
    AST_NO_FLAG: assert property (@(posedge clk) disable iff (!nrst)
        !torqueMode |=> !speedLimitDetected)
        else $error("flag outside torque mode");
    // Forward overspeed must brake with non-positive torque
    AST_OPPOSE: assert property (@(posedge clk) disable iff (!nrst)
        torqueMode && excess != '0 && !motorSpeed[SPD_W] |=> limitTorque <= 0)
        else $error("torque not opposing overspeed");
    AST_TORQUE: assert property (@(posedge clk) disable iff (!nrst)
        !torqueMode |=> limitTorque == '0)
        else $error("torque outside torque mode");
    AST_ACC: assert property (@(posedge clk) disable iff (!nrst)
        phase_r == SCG_ACCEL && accelSwitchSpeed == '0 |-> step == accelStepTwo)
        else $error("single-step accel wrong");
    AST_DEC: assert property (@(posedge clk) disable iff (!nrst)
        phase_r == SCG_DECEL && profileSpeed < decelSwitchSpeed |-> step == decelStepOne)
        else $error("decel step wrong");
    AST_ACC_ONE: assert property (@(posedge clk) disable iff (!nrst)
        phase_r == SCG_ACCEL && profileSpeed < accelSwitchSpeed |-> step == accelStepOne)
        else $error("first accel step wrong");
    AST_DEC_ZERO: assert property (@(posedge clk) disable iff (!nrst)
        phase_r == SCG_DECEL && decelSwitchSpeed == '0 |-> step == decelStepTwo)
        else $error("single-step decel wrong");
    // Filter bypass paths pass the profile through one cycle later
    AST_AVG_OFF: assert property (@(posedge clk) disable iff (!nrst)
        filterSelect == `SCG_FILT_AVG && movingAverageTime == '0
        |=> filteredSpeed == $past(profileSpeed))
        else $error("average bypass wrong");
    AST_NO_FILT: assert property (@(posedge clk) disable iff (!nrst)
        filterSelect == `SCG_FILT_NONE |=> filteredSpeed == $past(profileSpeed))
        else $error("unfiltered path wrong");
    // ----------------------------------------
    // Cover points
    // ----------------------------------------
    COV_LIMIT: cover property (@(posedge clk) speedLimitDetected);
    COV_ACCEL: cover property (@(posedge clk) phase_r == SCG_ACCEL ##1 phase_r == SCG_CRUISE);
    COV_DECEL: cover property (@(posedge clk) phase_r == SCG_DECEL ##1 phase_r == SCG_CRUISE);
    COV_EXP: cover property (@(posedge clk) filterSelect == `SCG_FILT_EXP && expDiff < 0);
endmodule : scg_servo_cond
`default_nettype wire

// ---- verif/scg_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Host controller: command pulses, gear and profile settings
// ----------------------------------------
module scg_host_model (
    input  wire logic          clk,
    output scg_pkg::scg_cmd_s  cmdIn,
    output logic [15:0]        gearNum,
    output logic [15:0]        gearDen,
    output logic [5:0][15:0]   prof
);
    import scg_pkg::*;
    // Quiet link at time zero
    initial begin
        cmdIn = '0;
        gearNum = 16'h0004;
        gearDen = 16'h0001;
        prof = '0;
    end
    // Callers keep the ratio inside 0.001..1000
    task automatic set_gear(input logic [15:0] n, input logic [15:0] d);
        @(posedge clk);
        gearNum <= n;
        gearDen <= d;
    endtask : set_gear
    // Profile settings as the link delivers them
    task automatic set_profile(input logic [5:0][15:0] p);
        @(posedge clk);
        prof <= p;
    endtask : set_profile
    // Back-to-back pulses; idle count shows inverted junk, not a stale value
    task automatic send_cmds(input logic [15:0] c, input int n);
        repeat (n) begin
            @(posedge clk);
            cmdIn <= '{valid: 1'b1, count: c};
        end
        @(posedge clk);
        cmdIn <= '{valid: 1'b0, count: ~c};
    endtask : send_cmds
endmodule : scg_host_model
`default_nettype wire

// ---- verif/scg_servo_cond_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module scg_servo_cond_tb_top;
    import scg_pkg::*;
    // Speed limit row: inputs, then expected flag and torque
    typedef struct {logic tm; logic signed [16:0] spd; logic [15:0] lim; logic [1:0] src;
        logic [16:0] opt; logic alloc; logic [15:0] gain; logic det; logic signed [17:0] trq;
    } scg_row_s;
    logic clk, nrst, torqueMode, speedLimitOutputAlloc, profileRun, speedLimitDetected;
    logic signed [16:0] motorSpeed;
    logic [15:0] maxMotorSpeed, torqueModeSpeedLimit, limitGain, targetSpeed, expFilterBias;
    logic [15:0] gearNum, gearDen, profileSpeed, filteredSpeed;
    logic [5:0][15:0] prof;
    logic [1:0] speedCommandSourceSelect, filterSelect;
    logic [16:0] optionCommand1;
    logic [31:0] feedbackPos, motorPulseTotal, deviationCmdUnits;
    logic [3:0] expFilterTimeConstant;
    logic [4:0] movingAverageTime;
    logic signed [17:0] limitTorque;
    scg_cmd_s cmdIn;
    int errTotal = 0, samplesChecked = 0, cycleCount = 0;
    // Max speed 5000 rpm; option 0c350 is 50 % = 2500 rpm
    scg_row_s rows [11] = '{
        '{1, 17'sh0bb8, 16'h07d0, 0, 17'h0, 1, 16'hffff, 1, -18'sh3e8},
        '{1, -17'sh0bb8, 16'h07d0, 0, 17'h0, 1, 16'hffff, 1, 18'sh3e8},
        '{1, 17'sh05dc, 16'h07d0, 0, 17'h0, 1, 16'hffff, 0, 18'sh0},
        '{1, 17'sh07d0, 16'h07d0, 0, 17'h0, 1, 16'hffff, 0, 18'sh0},
        '{1, 17'sh0bb8, 16'h0fa0, 1, 17'h0c350, 1, 16'hffff, 1, -18'sh1f4},
        '{1, -17'sh0bb8, 16'h0fa0, 1, 17'h0c350, 1, 16'hffff, 1, 18'sh1f4},
        '{1, 17'sh0bb8, 16'h07d0, 1, 17'h0c350, 1, 16'hffff, 1, -18'sh3e8},
        '{1, 17'sh0bb8, 16'h07d0, 0, 17'h0, 0, 16'hffff, 0, -18'sh3e8},
        '{0, 17'sh0bb8, 16'h07d0, 0, 17'h0, 1, 16'hffff, 0, 18'sh0},
        '{1, 17'sh2ee0, 16'hffff, 0, 17'h0, 1, 16'hffff, 1, -18'sh7d0},
        '{1, 17'sh0bb8, 16'h07d0, 0, 17'h0, 1, 16'h00ff, 1, -18'sh0e8}};
    // ----------------------------------------
    // Clock, design, host
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    scg_servo_cond scg_servo_cond_i (.clk(clk), .nrst(nrst), .cmdIn(cmdIn),
        .gearNumeratorParam(gearNum), .gearDenominatorParam(gearDen), .torqueMode(torqueMode),
        .motorSpeed(motorSpeed), .maxMotorSpeed(maxMotorSpeed),
        .torqueModeSpeedLimit(torqueModeSpeedLimit),
        .speedCommandSourceSelect(speedCommandSourceSelect), .optionCommand1(optionCommand1),
        .speedLimitOutputAlloc(speedLimitOutputAlloc), .limitGain(limitGain),
        .feedbackPos(feedbackPos), .accelStepOne(prof[0]), .accelStepTwo(prof[1]),
        .accelSwitchSpeed(prof[2]), .decelStepOne(prof[3]), .decelStepTwo(prof[4]),
        .decelSwitchSpeed(prof[5]), .targetSpeed(targetSpeed), .profileRun(profileRun),
        .filterSelect(filterSelect), .expFilterBias(expFilterBias),
        .expFilterTimeConstant(expFilterTimeConstant), .movingAverageTime(movingAverageTime),
        .motorPulseTotal(motorPulseTotal), .deviationCmdUnits(deviationCmdUnits),
        .limitTorque(limitTorque), .speedLimitDetected(speedLimitDetected),
        .profileSpeed(profileSpeed), .filteredSpeed(filteredSpeed));
    scg_host_model scg_host_model_i (.clk(clk), .cmdIn(cmdIn), .gearNum(gearNum),
        .gearDen(gearDen), .prof(prof));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check_value(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samplesChecked++;
        if (got !== exp) begin
            errTotal++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask : check_value
    // Reset acts as a power cycle; gear caught at the first edge after release
    task automatic do_reset(input logic [15:0] n, input logic [15:0] d);
        scg_host_model_i.set_gear(n, d);
        nrst <= 1'b0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
    endtask : do_reset
    // Pulses sent back to back; total is floor of cumulative count times ratio
    task automatic gear_case(input logic [15:0] n, d, c, input int k, input longint exp);
        scg_host_model_i.send_cmds(c, k);
        @(negedge clk);
        check_value("pulse total", exp[31:0], motorPulseTotal);
    endtask : gear_case
    // Watch each step of the profile against its phase setting
    task automatic profile_run(input logic [15:0] tgt, st1, st2, sw, input logic up);
        logic [15:0] prev;
        logic [15:0] stp;
        @(posedge clk);
        targetSpeed <= tgt;
        profileRun <= 1'b1;
        @(negedge clk);
        prev = profileSpeed;
        repeat (40) begin
            @(negedge clk);
            stp = (prev < sw) ? st1 : st2;
            if (profileSpeed !== prev && (up ? prev + stp <= tgt : prev >= tgt + stp))
                check_value("profile step", 32'(up ? prev + stp : prev - stp), 32'(profileSpeed));
            prev = profileSpeed;
        end
        check_value("profile end", 32'(tgt), 32'(profileSpeed));
    endtask : profile_run
    task automatic close_out;
        $display("checks %0d mismatches %0d", samplesChecked, errTotal);
        if (errTotal == 0 && samplesChecked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out
    // Hang guard, far above the planned run length
    always @(posedge clk) begin
        cycleCount <= cycleCount + 1;
        if (cycleCount == 20000) begin
            errTotal++;
            close_out();
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {nrst, torqueMode, speedLimitOutputAlloc, profileRun} = '0;
        {motorSpeed, torqueModeSpeedLimit, speedCommandSourceSelect, optionCommand1} = '0;
        {limitGain, feedbackPos, targetSpeed, filterSelect, expFilterBias} = '0;
        {expFilterTimeConstant, movingAverageTime} = '0;
        maxMotorSpeed = 16'h1388;
        repeat (20) @(posedge clk);
        @(negedge clk);
        check_value("reset total", 32'h0, motorPulseTotal);
        check_value("reset flag", 32'h0, 32'(speedLimitDetected));
        @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        foreach (rows[i]) begin
            @(posedge clk);
            {torqueMode, motorSpeed, torqueModeSpeedLimit} <= {rows[i].tm, rows[i].spd, rows[i].lim};
            {speedCommandSourceSelect, optionCommand1} <= {rows[i].src, rows[i].opt};
            {speedLimitOutputAlloc, limitGain} <= {rows[i].alloc, rows[i].gain};
            repeat (2) @(posedge clk);
            @(negedge clk);
            check_value("limit flag", 32'(rows[i].det), 32'(speedLimitDetected));
            check_value("limit torque", 32'(rows[i].trq), 32'(limitTorque));
        end
        // Gear ratios kept within 0.001..1000
        do_reset(16'h0004, 16'h0001);
        gear_case(16'h0004, 16'h0001, 16'h0001, 3, 12);
        do_reset(16'h0001, 16'h0001);
        gear_case(16'h0001, 16'h0001, 16'h0100, 4, 1024);
        do_reset(16'h0003, 16'h0002);
        gear_case(16'h0003, 16'h0002, 16'h0001, 5, 7);
        // Six encoder counts at 3/2 are four command units; five sent
        @(posedge clk);
        feedbackPos <= 32'h6;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check_value("deviation", 32'h1, deviationCmdUnits);
        do_reset(16'h2000, 16'h03e8);
        gear_case(16'h2000, 16'h03e8, 16'h0007, 4, 229);
        do_reset(16'h0001, 16'h03e8);
        gear_case(16'h0001, 16'h03e8, 16'h01f4, 3, 1);
        // Edited gear stays out until the next reset
        do_reset(16'h0003, 16'h0002);
        scg_host_model_i.set_gear(16'h0001, 16'h0001);
        gear_case(16'h0003, 16'h0002, 16'h0001, 4, 6);
        do_reset(16'h0001, 16'h0001);
        gear_case(16'h0001, 16'h0001, 16'h0001, 4, 4);
        // Two-step profile, then single-step with both switch speeds at zero
        torqueMode <= 1'b0;
        scg_host_model_i.set_profile({16'h000c, 16'h0007, 16'h0002, 16'h000a, 16'h0005, 16'h0003});
        profile_run(16'h001e, 16'h0003, 16'h0005, 16'h000a, 1'b1);
        profile_run(16'h0004, 16'h0002, 16'h0007, 16'h000c, 1'b0);
        scg_host_model_i.set_profile({16'h0000, 16'h0003, 16'h0009, 16'h0000, 16'h0004, 16'h0009});
        profile_run(16'h0014, 16'h0009, 16'h0004, 16'h0000, 1'b1);
        profile_run(16'h0002, 16'h0009, 16'h0003, 16'h0000, 1'b0);
        // Filters at a steady speed of 2; exp decays from above with bias past speed
        @(posedge clk);
        filterSelect <= 2'h2;
        movingAverageTime <= 5'h01;
        repeat (20) @(posedge clk);
        @(negedge clk);
        check_value("average filter", 32'h2, 32'(filteredSpeed));
        @(posedge clk);
        filterSelect <= 2'h1;
        expFilterBias <= 16'h0010;
        expFilterTimeConstant <= 4'h4;
        repeat (300) @(posedge clk);
        @(negedge clk);
        check_value("exp filter", 32'h2, 32'(filteredSpeed));
        @(posedge clk);
        filterSelect <= 2'h0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check_value("no filter", 32'h2, 32'(filteredSpeed));
        close_out();
    end
endmodule : scg_servo_cond_tb_top
`default_nettype wire
